// file: verilog/ecd_pkg.sv
// Package: register map, mode fields, states and transfer carrier of the DMA controller
package ecd_pkg;
	// Channel count and register block layout
	localparam int NUM_CH = 8;
	localparam logic [35:0] PHYS_BASE = 36'h014002000;
	localparam logic [31:0] KSEG_BASE = 32'hb4002000;
	localparam logic [11:0] CH_STRIDE = 12'h100;

	// Offsets inside one channel block
	localparam logic [7:0] OFF_MODE_SET = 8'h00;
	localparam logic [7:0] OFF_MODE_CLR = 8'h04;
	localparam logic [7:0] OFF_PER_ADDR = 8'h08;
	localparam logic [7:0] OFF_BUFA_ADDR = 8'h0c;
	localparam logic [7:0] OFF_BUFA_SIZE = 8'h10;
	localparam logic [7:0] OFF_BUFB_ADDR = 8'h14;
	localparam logic [7:0] OFF_BUFB_SIZE = 8'h18;

	// Word store slots per channel
	localparam logic [1:0] SLOT_PER = 2'h0;
	localparam logic [1:0] SLOT_BUFA = 2'h1;
	localparam logic [1:0] SLOT_BUFB = 2'h2;

	// Mode register fields
	localparam int DAH_LSB = 20;
	localparam int SEL_LSB = 16;
	localparam int BANK_BIT = 15;
	localparam int ENDIAN_BIT = 13;
	localparam int DIR_BIT = 12;
	localparam int BURST_BIT = 11;
	localparam int WIDTH_LSB = 9;
	localparam int HALT_BIT = 6;
	localparam int GO_BIT = 5;
	localparam logic [31:0] MODE_WMASK = 32'h00ffbfa0;
	localparam logic [31:0] MODE_RST = 32'h00000000;

	// Remaining count width and bank 1 valid selector range
	localparam int CNT_W = 16;
	localparam logic [CNT_W-1:0] CNT_RST = 16'h0000;
	localparam logic [3:0] BANK1_IDS = 4'h4;
	localparam logic [3:0] BURST_SHORT = 4'h4;
	localparam logic [3:0] BURST_LONG = 4'h8;

	// Datum widths
	localparam logic [1:0] DW_8 = 2'h0;
	localparam logic [1:0] DW_16 = 2'h1;

	// Engine states, Gray along idle, load, move
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_PER = 3'b001,
		ST_BUF = 3'b011,
		ST_BASE = 3'b010,
		ST_MOVE = 3'b110,
		ST_WRAP = 3'b111
	} ecd_state_t;

	// One datum beat offered to the system bus
	typedef struct packed {
		logic [2:0] chan;
		logic [35:0] dev_addr;
		logic [31:0] mem_addr;
		logic to_mem;
		logic [1:0] width;
		logic big_endian;
		logic last;
	} ecd_xfer_t;
endpackage

// file: verilog/ecd_word_store.sv
// Word store for the per-channel address registers, with registered read ports
`timescale 1ns/1ps
module ecd_word_store (
	input wire logic core_clk_i,
	input wire logic reset_i,
	input wire logic wr_en_i,
	input wire logic [4:0] wr_idx_i,
	input wire logic [31:0] wr_data_i,
	input wire logic rd_en_i,
	input wire logic rd_mem_i,
	input wire logic [4:0] rd_idx_i,
	input wire logic [31:0] rd_alt_i,
	output logic [31:0] rd_data_o,
	input wire logic [4:0] eng_idx_i,
	output logic [31:0] eng_data_o
);
	logic [31:0] mem [32];

	// Storage has no reset; software programs it before enabling a channel
	always_ff @(posedge core_clk_i) begin
		if (wr_en_i) begin
			mem[wr_idx_i] <= wr_data_i;
		end
	end

	// Bus read word stands for one cycle only; other registers ride the bypass
	always_ff @(posedge core_clk_i or posedge reset_i) begin
		if (reset_i) begin
			rd_data_o <= 32'h00000000;
			eng_data_o <= 32'h00000000;
		end else begin
			rd_data_o <= !rd_en_i ? 32'h00000000 : (rd_mem_i ? mem[rd_idx_i] : rd_alt_i);
			eng_data_o <= mem[eng_idx_i];
		end
	end
endmodule

// file: verilog/ecd_dma_top.sv
// Eight-channel DMA controller: channel registers, arbiter and burst engine
//
// Notes on behaviour
// RL1 - Eight channels, each with its own register block.
// RL2 - Channels move data between memory and 20 peripherals or external FIFO.
// RL3 - Two external request pins act as bank 0 selectors 2 and 3.
// RL4 - Channel blocks step by 0x100 from the channel 0 base.
// RL5 - Fixed priority: channel 0 highest, channel 7 lowest.
// RL6 - Decode mode set/read, clear, peripheral address, two address/size pairs.
// RL7 - Two buffers each; size write programs count, read returns remaining.
// RL8 - Mode set write sets bits written one; read returns mode.
// RL9 - Mode clear write clears bits written one, others unchanged.
// RL10 - Software puts FIFO address in peripheral register and high bits.
// RL11 - Software never enables two channels with the same selector.
// RL12 - Peripheral chosen by bank bit plus 4-bit selector; bank 1 4-15 reserved.
// RL13 - Serial port peripherals use 8-bit width, programmable size.
// RL14 - USB endpoints on bank 0 selectors 8 to 13, size 4, width 8.
// RL15 - Audio link selectors 4/5 width 16; serial audio 14/15.
// RL16 - Mode holds address-high 23:20, selector 19:16, bank bit 15.
// RL17 - Mode bit 12 picks direction: zero memory to device.
// RL18 - Bit 11 picks 4 or 8 datums; bits 10:9 datum width.
// RL19 - Burst starts only on peripheral request; highest priority requester wins.
// RL20 - Mode registers read zero after reset; channels idle.
//
// Implementation choice: the plain strobed port.
`timescale 1ns/1ps
module ecd_dma_top (
	input wire logic core_clk_i,
	input wire logic reset_i,
	input wire logic [10:0] reg_addr_i,
	input wire logic [31:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	output logic [31:0] reg_rdata_o,
	input wire logic [13:0] bank0_req_i,
	input wire logic [3:0] bank1_req_i,
	input wire logic external_request_a_i,
	input wire logic external_request_b_i,
	output ecd_pkg::ecd_xfer_t xfer_o,
	output logic xfer_valid_o,
	input wire logic xfer_ready_i,
	output logic [7:0] chan_busy_o
);
	// Bank-select plus selector lookup into the request vectors
	// Bank 1 selectors 4 to 15 are reserved and never raise a request
	function automatic logic sel_req(input logic bank, input logic [3:0] id,
		input logic [15:0] r0, input logic [3:0] r1);
		logic hit;
		hit = 1'b0;
		if (!bank) begin
			hit = r0[id];
		end else if (id < ecd_pkg::BANK1_IDS) begin
			hit = r1[id[1:0]];
		end
		return hit;
	endfunction

	// Bytes per datum; the reserved width code is treated as a full word
	// Memory addresses step by this amount after every accepted beat
	function automatic logic [31:0] datum_bytes(input logic [1:0] dw);
		logic [31:0] b;
		b = 32'h00000004;
		if (dw == ecd_pkg::DW_8) begin
			b = 32'h00000001;
		end else if (dw == ecd_pkg::DW_16) begin
			b = 32'h00000002;
		end
		return b;
	endfunction

	// Lowest set index wins
	// The loop runs downward so the last hit seen is the highest priority
	function automatic logic [2:0] first_set(input logic [7:0] v);
		logic [2:0] idx;
		idx = 3'h0;
		for (int k = ecd_pkg::NUM_CH - 1; k >= 0; k--) begin
			if (v[k]) begin
				idx = 3'(k);
			end
		end
		return idx;
	endfunction

	// Bus decode: channel in the upper bits, byte offset below
	// Only the block-relative part of the address is decoded; the base is fixed
	wire [2:0] bus_ch = reg_addr_i[10:8]; // RL4
	wire [7:0] bus_off = reg_addr_i[7:0];
	wire is_mode = bus_off == ecd_pkg::OFF_MODE_SET;
	wire is_clr = bus_off == ecd_pkg::OFF_MODE_CLR;
	wire is_per = bus_off == ecd_pkg::OFF_PER_ADDR;
	wire is_bufa = bus_off == ecd_pkg::OFF_BUFA_ADDR;
	wire is_sizea = bus_off == ecd_pkg::OFF_BUFA_SIZE;
	wire is_bufb = bus_off == ecd_pkg::OFF_BUFB_ADDR;
	wire is_sizeb = bus_off == ecd_pkg::OFF_BUFB_SIZE;
	wire is_word = is_per | is_bufa | is_bufb; // RL6
	wire [1:0] word_slot = is_per ? ecd_pkg::SLOT_PER :
		(is_bufa ? ecd_pkg::SLOT_BUFA : ecd_pkg::SLOT_BUFB);
	wire [4:0] bus_idx = {bus_ch, word_slot};
	wire [31:0] wr_bits = reg_wdata_i & ecd_pkg::MODE_WMASK;

	// External pins take the bank 0 slots 2 and 3
	// The pins are used as plain levels; whoever drives them keeps them synchronous
	wire [15:0] req0 = {bank0_req_i[13:2], external_request_b_i, external_request_a_i,
		bank0_req_i[1:0]}; // RL3
	wire [3:0] req1 = bank1_req_i; // RL2

	// Channel state
	// Mode, halt and counts are per channel; addresses sit in the word store
	logic [31:0] mode_q [8];
	logic [7:0] halt_q;
	logic [7:0] armed_q;
	logic [ecd_pkg::CNT_W-1:0] prog_q [8][2];
	logic [ecd_pkg::CNT_W-1:0] remain_q [8][2];
	logic [7:0] ch_req;

	// Engine state
	// One engine serves all channels, one burst at a time
	ecd_pkg::ecd_state_t state_q;
	logic [2:0] cur_q;
	logic buf_sel_q;
	logic [3:0] beat_q;
	logic [3:0] blen_q;
	logic [31:0] per_q;
	ecd_pkg::ecd_xfer_t xfer_q;
	logic xfer_valid_q;
	logic [7:0] busy_q;
	wire beat_acc = xfer_valid_q & xfer_ready_i;
	wire engine_busy = state_q != ecd_pkg::ST_IDLE;

	genvar gi;
	genvar gb;
	generate
		for (gi = 0; gi < ecd_pkg::NUM_CH; gi++) begin : g_ch
			wire hit = reg_wr_i & (bus_ch == 3'(gi)); // RL1
			wire set_w = hit & is_mode;
			wire clr_w = hit & is_clr;
			wire go = mode_q[gi][ecd_pkg::GO_BIT];
			wire bank = mode_q[gi][ecd_pkg::BANK_BIT]; // RL16
			wire [3:0] id = mode_q[gi][ecd_pkg::SEL_LSB +: 4]; // RL12
			wire has_work = (remain_q[gi][0] != ecd_pkg::CNT_RST) |
				(remain_q[gi][1] != ecd_pkg::CNT_RST); // RL7
			wire [31:0] mode_d = set_w ? (mode_q[gi] | wr_bits) :
				(clr_w ? (mode_q[gi] & ~wr_bits) : mode_q[gi]);

			// A channel asks for the bus only when enabled and its peripheral asks
			assign ch_req[gi] = go & has_work & sel_req(bank, id, req0, req1); // RL19

			// Mode bits change only through set and clear writes
			// Bit 6 is never stored here; halt is merged in on the read path
			always_ff @(posedge core_clk_i or posedge reset_i) begin
				if (reset_i) begin
					mode_q[gi] <= ecd_pkg::MODE_RST; // RL20
				end else begin
					mode_q[gi] <= mode_d; // RL8 RL9
				end
			end

			// Halt follows a cleared go once the channel has left the engine
			// A channel never enabled stays un-halted, so reset status reads zero
			// Setting go again drops halt in the next cycle
			always_ff @(posedge core_clk_i or posedge reset_i) begin
				if (reset_i) begin
					halt_q[gi] <= 1'b0;
					armed_q[gi] <= 1'b0;
				end else begin
					armed_q[gi] <= go | (armed_q[gi] & ~halt_q[gi]);
					halt_q[gi] <= !go & (halt_q[gi] | (armed_q[gi] & ~busy_q[gi]));
				end
			end

			for (gb = 0; gb < 2; gb++) begin : g_buf
				wire size_w = hit & (gb == 0 ? is_sizea : is_sizeb);
				wire dec = beat_acc & (cur_q == 3'(gi)) & (buf_sel_q == 1'(gb));

				// A size write restarts the count even during a burst
				// Rewriting a live count may leave the running burst short
				always_ff @(posedge core_clk_i or posedge reset_i) begin
					if (reset_i) begin
						prog_q[gi][gb] <= ecd_pkg::CNT_RST;
						remain_q[gi][gb] <= ecd_pkg::CNT_RST;
					end else if (size_w) begin
						prog_q[gi][gb] <= reg_wdata_i[ecd_pkg::CNT_W-1:0]; // RL7
						remain_q[gi][gb] <= reg_wdata_i[ecd_pkg::CNT_W-1:0];
					end else if (dec) begin
						remain_q[gi][gb] <= remain_q[gi][gb] - 1'b1; // RL7
					end
				end
			end
		end
	endgenerate

	// Read data for the registers kept outside the word store
	// Only the remaining count is visible; the programmed size stays internal
	wire [31:0] mode_rd = mode_q[bus_ch] | ({31'h0, halt_q[bus_ch]} << ecd_pkg::HALT_BIT);
	wire [31:0] rd_alt = is_mode ? mode_rd : // RL8
		(is_sizea ? {16'h0, remain_q[bus_ch][0]} :
		(is_sizeb ? {16'h0, remain_q[bus_ch][1]} : 32'h00000000)); // RL6

	// Arbitration and fields of the winning channel
	// Fixed priority lets a busy channel 0 starve the others while it asks
	// The first beat address resumes from the part of the buffer already moved
	wire any_req = |ch_req;
	wire [2:0] win = first_set(ch_req); // RL5
	wire [31:0] win_mode = mode_q[win];
	wire win_buf = remain_q[win][0] == ecd_pkg::CNT_RST;
	wire [31:0] cur_mode = mode_q[cur_q];
	wire [1:0] cur_dw = cur_mode[ecd_pkg::WIDTH_LSB +: 2]; // RL18
	wire [31:0] step = datum_bytes(cur_dw);
	wire [ecd_pkg::CNT_W-1:0] cur_remain = remain_q[cur_q][buf_sel_q];
	wire [ecd_pkg::CNT_W-1:0] cur_done = prog_q[cur_q][buf_sel_q] - cur_remain;
	wire [31:0] base_off = {16'h0, cur_done} * step;
	wire [1:0] eng_slot = buf_sel_q ? ecd_pkg::SLOT_BUFB : ecd_pkg::SLOT_BUFA;
	wire [4:0] eng_idx = state_q == ecd_pkg::ST_PER ? {cur_q, ecd_pkg::SLOT_PER} :
		{cur_q, eng_slot};
	wire [31:0] eng_data;
	wire [3:0] beat_nx = beat_q + 4'h1;
	wire last_nx = (beat_nx == blen_q - 4'h1) | (cur_remain == 16'h0002);

	// Address registers and read data live in the word store
	// The engine port costs one cycle per lookup, hence the load states
	ecd_word_store u_store (
		.core_clk_i(core_clk_i),
		.reset_i(reset_i),
		.wr_en_i(reg_wr_i & is_word),
		.wr_idx_i(bus_idx),
		.wr_data_i(reg_wdata_i),
		.rd_en_i(reg_rd_i),
		.rd_mem_i(is_word),
		.rd_idx_i(bus_idx),
		.rd_alt_i(rd_alt),
		.rd_data_o(reg_rdata_o),
		.eng_idx_i(eng_idx),
		.eng_data_o(eng_data)
	);

	// Next engine state
	// Idle, peripheral load, buffer load, base add, move, then one wrap cycle
	// The wrap cycle separates bursts so the counts settle before the next pick
	ecd_pkg::ecd_state_t state_d;
	always_comb begin
		state_d = state_q;
		unique case (state_q)
			ecd_pkg::ST_IDLE: begin
				if (any_req) begin
					state_d = ecd_pkg::ST_PER; // RL19
				end
			end
			ecd_pkg::ST_PER: begin
				state_d = ecd_pkg::ST_BUF;
			end
			ecd_pkg::ST_BUF: begin
				state_d = ecd_pkg::ST_BASE;
			end
			ecd_pkg::ST_BASE: begin
				state_d = ecd_pkg::ST_MOVE;
			end
			ecd_pkg::ST_MOVE: begin
				if (beat_acc & xfer_q.last) begin
					state_d = ecd_pkg::ST_WRAP;
				end
			end
			ecd_pkg::ST_WRAP: begin
				state_d = ecd_pkg::ST_IDLE;
			end
			default: begin
				state_d = ecd_pkg::ST_IDLE;
			end
		endcase
	end

	// State register
	always_ff @(posedge core_clk_i or posedge reset_i) begin
		if (reset_i) begin
			state_q <= ecd_pkg::ST_IDLE;
		end else begin
			state_q <= state_d;
		end
	end

	// Winner is latched once; a lower channel waits for the whole burst
	// A request that drops mid-burst does not cut the burst short
	always_ff @(posedge core_clk_i or posedge reset_i) begin
		if (reset_i) begin
			cur_q <= 3'h0;
			buf_sel_q <= 1'b0;
			blen_q <= ecd_pkg::BURST_SHORT;
		end else if (state_q == ecd_pkg::ST_IDLE && any_req) begin
			cur_q <= win; // RL5
			buf_sel_q <= win_buf; // RL7
			blen_q <= win_mode[ecd_pkg::BURST_BIT] ? ecd_pkg::BURST_LONG :
				ecd_pkg::BURST_SHORT; // RL18
		end
	end

	// Peripheral FIFO address arrives one cycle after its slot is read
	always_ff @(posedge core_clk_i or posedge reset_i) begin
		if (reset_i) begin
			per_q <= 32'h00000000;
		end else if (state_q == ecd_pkg::ST_BUF) begin
			per_q <= eng_data; // RL10
		end
	end

	// Beat offer: first beat resumes where the remaining count left off
	// An offered beat holds every field until the system bus takes it
	// The last flag is worked out one beat ahead so it stands with its beat
	always_ff @(posedge core_clk_i or posedge reset_i) begin
		if (reset_i) begin
			xfer_q <= '0;
			xfer_valid_q <= 1'b0;
			beat_q <= 4'h0;
		end else if (state_q == ecd_pkg::ST_BASE) begin
			xfer_q.chan <= cur_q;
			xfer_q.dev_addr <= {cur_mode[ecd_pkg::DAH_LSB +: 4], per_q}; // RL16
			xfer_q.mem_addr <= eng_data + base_off;
			xfer_q.to_mem <= cur_mode[ecd_pkg::DIR_BIT]; // RL17
			xfer_q.width <= cur_dw; // RL13 RL14 RL15
			xfer_q.big_endian <= cur_mode[ecd_pkg::ENDIAN_BIT];
			xfer_q.last <= cur_remain == 16'h0001;
			xfer_valid_q <= 1'b1;
			beat_q <= 4'h0;
		end else if (beat_acc) begin
			xfer_q.mem_addr <= xfer_q.mem_addr + step;
			xfer_q.last <= last_nx; // RL18
			xfer_valid_q <= !xfer_q.last;
			beat_q <= beat_nx;
		end
	end

	// Busy flags feed the halt status of each channel
	// They lag the engine state by one cycle, which halt tolerates
	always_ff @(posedge core_clk_i or posedge reset_i) begin
		if (reset_i) begin
			busy_q <= 8'h00;
		end else begin
			busy_q <= engine_busy ? (8'h01 << cur_q) : 8'h00;
		end
	end

	// The peripheral FIFO address is not checked against the selector; the
	// device trusts software here, which keeps the engine free of lookup tables.
	// Width and burst length are likewise left for software to match the FIFO.
	// Two channels on one selector would race for the same FIFO requests. RL11
	assign xfer_o = xfer_q;
	assign xfer_valid_o = xfer_valid_q;
	assign chan_busy_o = busy_q;
endmodule

// file: verif/ecd_dma_monitor.sv
// Port-level concurrent checks for the DMA controller
`timescale 1ns/1ps
module ecd_dma_monitor (
	input wire logic core_clk_i,
	input wire logic reset_i,
	input wire logic [10:0] reg_addr_i,
	input wire logic [31:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	input wire logic [31:0] reg_rdata_o,
	input wire logic [13:0] bank0_req_i,
	input wire logic [3:0] bank1_req_i,
	input wire logic external_request_a_i,
	input wire logic external_request_b_i,
	input wire ecd_pkg::ecd_xfer_t xfer_o,
	input wire logic xfer_valid_o,
	input wire logic xfer_ready_i,
	input wire logic [7:0] chan_busy_o
);
	logic any_req;
	logic [31:0] step_w;
	logic [3:0] beat_q;
	logic acc;
	// Any peripheral asking, and the address step the width implies
	assign any_req = (|bank0_req_i) | (|bank1_req_i) | external_request_a_i | external_request_b_i;
	assign step_w = (xfer_o.width == 2'h0) ? 32'h1 : ((xfer_o.width == 2'h1) ? 32'h2 : 32'h4);
	assign acc = xfer_valid_o & xfer_ready_i;
	// Beats accepted in the current burst
	always_ff @(posedge core_clk_i or posedge reset_i) begin
		if (reset_i) begin
			beat_q <= 4'h0;
		end else if (acc) begin
			beat_q <= xfer_o.last ? 4'h0 : beat_q + 4'h1;
		end
	end
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (reset_i);
	chk_rdata_quiet: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 32'h0)
		else $error("read data not zero outside answer cycle");
	chk_beat_hold: assert property (xfer_valid_o && !xfer_ready_i |=>
		xfer_valid_o && $stable(xfer_o))
		else $error("offered beat changed before acceptance");
	chk_busy_onehot: assert property ($onehot0(chan_busy_o))
		else $error("more than one channel busy");
	chk_start_on_req: assert property ($rose(xfer_valid_o) |-> $past(any_req, 4))
		else $error("burst started without a request");
	chk_last_gap: assert property (acc && xfer_o.last |=> !xfer_valid_o [*4])
		else $error("beat offered too soon after burst end");
	chk_busy_match: assert property (xfer_valid_o |-> chan_busy_o == (8'h01 << xfer_o.chan))
		else $error("busy flag does not match beat channel");
	chk_addr_step: assert property (acc && !xfer_o.last |=>
		xfer_valid_o && xfer_o.mem_addr == $past(xfer_o.mem_addr) + $past(step_w))
		else $error("memory address step wrong");
	chk_chan_steady: assert property (acc && !xfer_o.last |=>
		xfer_o.chan == $past(xfer_o.chan) && xfer_o.dev_addr == $past(xfer_o.dev_addr))
		else $error("channel or device address changed in burst");
	chk_burst_max: assert property (acc |-> beat_q < 4'h8)
		else $error("burst longer than eight beats");
endmodule
bind ecd_dma_top ecd_dma_monitor u_mon (.core_clk_i(core_clk_i), .reset_i(reset_i),
	.reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
	.reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .bank0_req_i(bank0_req_i),
	.bank1_req_i(bank1_req_i), .external_request_a_i(external_request_a_i),
	.external_request_b_i(external_request_b_i), .xfer_o(xfer_o),
	.xfer_valid_o(xfer_valid_o), .xfer_ready_i(xfer_ready_i), .chan_busy_o(chan_busy_o));

// file: verif/ecd_sysbus_model.sv
// System bus model that accepts transfer beats promptly or with stalls
`timescale 1ns/1ps
module ecd_sysbus_model (
	input wire logic core_clk_i,
	input wire logic reset_i,
	input wire logic slow_i,
	output logic ready_o
);
	// Slow mode refuses every other cycle so an offered beat must hold
	always_ff @(posedge core_clk_i or posedge reset_i) begin
		if (reset_i) begin
			ready_o <= 1'b0;
		end else begin
			ready_o <= slow_i ? ~ready_o : 1'b1;
		end
	end
endmodule

// file: verif/tb_top.sv
// Testbench: register access and burst transfers of the DMA controller
`timescale 1ns/1ps
module tb_top;
	logic core_clk_i = 1'b0;
	logic reset_i = 1'b1;
	logic [10:0] reg_addr_i = 11'h000;
	logic [31:0] reg_wdata_i = 32'h00000000;
	logic reg_wr_i = 1'b0;
	logic reg_rd_i = 1'b0;
	logic [31:0] reg_rdata_o;
	logic [13:0] bank0_req_i = 14'h0000;
	logic [3:0] bank1_req_i = 4'h0;
	logic external_request_a_i = 1'b0;
	logic external_request_b_i = 1'b0;
	ecd_pkg::ecd_xfer_t xfer_o;
	logic xfer_valid_o;
	logic xfer_ready_i;
	logic [7:0] chan_busy_o;
	logic slow = 1'b0;
	int failures = 0;
	int cmp_count = 0;
	int cycles = 0;
	ecd_dma_top uut (.core_clk_i(core_clk_i), .reset_i(reset_i), .reg_addr_i(reg_addr_i),
		.reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
		.reg_rdata_o(reg_rdata_o), .bank0_req_i(bank0_req_i), .bank1_req_i(bank1_req_i),
		.external_request_a_i(external_request_a_i),
		.external_request_b_i(external_request_b_i), .xfer_o(xfer_o),
		.xfer_valid_o(xfer_valid_o), .xfer_ready_i(xfer_ready_i), .chan_busy_o(chan_busy_o));
	ecd_sysbus_model u_bus (.core_clk_i(core_clk_i), .reset_i(reset_i), .slow_i(slow),
		.ready_o(xfer_ready_i));
	// Clock, reset and a hang guard sized well above the whole sequence
	initial begin
		forever #2.5 core_clk_i = ~core_clk_i;
	end
	initial begin
		repeat (6) @(posedge core_clk_i);
		reset_i <= 1'b0;
	end
	always @(posedge core_clk_i) begin
		cycles++;
		if (cycles == 20000) begin
			failures++;
			end_sim();
		end
	end
	task automatic end_sim();
		$display("checks=%0d mismatches=%0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			failures++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [10:0] a, input logic [31:0] d);
		@(posedge core_clk_i);
		reg_wr_i <= 1'b1;
		reg_addr_i <= a;
		reg_wdata_i <= d;
		@(posedge core_clk_i);
		reg_wr_i <= 1'b0;
	endtask
	// Read data stand only in the cycle after the strobe
	task automatic rd(input logic [10:0] a, output logic [31:0] v);
		@(posedge core_clk_i);
		reg_rd_i <= 1'b1;
		reg_addr_i <= a;
		@(posedge core_clk_i);
		reg_rd_i <= 1'b0;
		#1 v = reg_rdata_o;
	endtask
	// Follow n accepted beats; sampling at the falling edge avoids edge races
	task automatic beats(input logic [2:0] ch, input int n, input logic [35:0] dev,
		input logic [31:0] mem, input int step, input logic tm, input logic [1:0] w, input logic be);
		int k;
		for (int i = 0; i < n; i++) begin
			k = 0;
			do begin
				@(negedge core_clk_i);
				k++;
			end while (!(xfer_valid_o === 1'b1 && xfer_ready_i === 1'b1) && k < 200);
			chk(k < 200, 1'b1);
			chk(xfer_o.chan, ch);
			chk(chan_busy_o, 8'h01 << ch);
			chk(xfer_o.dev_addr, dev);
			chk(xfer_o.mem_addr, mem + i * step);
			chk({xfer_o.to_mem, xfer_o.width, xfer_o.big_endian}, {tm, w, be});
			chk(xfer_o.last, i == n - 1);
		end
	endtask
	initial begin
		logic [31:0] v;
		logic [7:0] offs [5];
		logic [31:0] d;
		offs = '{8'h08, 8'h0c, 8'h10, 8'h14, 8'h18};
		@(negedge reset_i);
		for (int c = 0; c < 8; c++) begin
			rd({c[2:0], 8'h00}, v);
			chk(v, 32'h0);
		end
		$display("test reset_values done");
		wr(11'h300, 32'hffffffff);
		rd(11'h300, v);
		chk(v & 32'hffffffbf, ecd_pkg::MODE_WMASK);
		rd(11'h400, v);
		chk(v, 32'h0);
		wr(11'h304, 32'h00f00020);
		rd(11'h300, v);
		chk(v & 32'hffffffbf, 32'h000fbf80);
		rd(11'h304, v);
		chk(v, 32'h0);
		wr(11'h31c, 32'h00000001);
		rd(11'h31c, v);
		chk(v, 32'h0);
		wr(11'h304, 32'hffffffff);
		$display("test mode_set_clear done");
		for (int i = 0; i < 5; i++) begin
			d = {8'h5a, offs[i], 16'h1234};
			wr({3'h5, offs[i]}, d);
			rd({3'h5, offs[i]}, v);
			chk(v, (offs[i] == 8'h10 || offs[i] == 8'h18) ? {16'h0, d[15:0]} : d);
		end
		$display("test address_registers done");
		wr(11'h208, 32'h10000008);
		wr(11'h20c, 32'h00001000);
		wr(11'h210, 32'h00000006);
		wr(11'h200, 32'h00141220);
		rd(11'h200, v);
		chk(v & 32'hffffffbf, 32'h00141220);
		@(posedge core_clk_i);
		slow <= 1'b1;
		bank0_req_i[2] <= 1'b1;
		beats(3'h2, 4, 36'h110000008, 32'h00001000, 2, 1'b1, 2'h1, 1'b0);
		rd(11'h210, v);
		chk(v, 32'h2);
		slow <= 1'b0;
		beats(3'h2, 2, 36'h110000008, 32'h00001008, 2, 1'b1, 2'h1, 1'b0);
		repeat (10) @(negedge core_clk_i);
		chk(xfer_valid_o, 1'b0);
		@(posedge core_clk_i);
		bank0_req_i[2] <= 1'b0;
		$display("test burst_cut_short done");
		wr(11'h108, 32'h20000000);
		wr(11'h10c, 32'h00004000);
		wr(11'h110, 32'h00000008);
		wr(11'h608, 32'h10600004);
		wr(11'h60c, 32'h00005000);
		wr(11'h610, 32'h00000004);
		wr(11'h600, 32'h00019020);
		wr(11'h100, 32'h00020c20);
		@(posedge core_clk_i);
		bank1_req_i[1] <= 1'b1;
		external_request_a_i <= 1'b1;
		beats(3'h1, 8, 36'h020000000, 32'h00004000, 4, 1'b0, 2'h2, 1'b0);
		beats(3'h6, 4, 36'h010600004, 32'h00005000, 1, 1'b1, 2'h0, 1'b0);
		$display("test priority done");
		wr(11'h408, 32'h10200010);
		wr(11'h414, 32'h00006000);
		wr(11'h418, 32'h00000004);
		wr(11'h400, 32'h000c3020);
		wr(11'h708, 32'h30000000);
		wr(11'h70c, 32'h00007000);
		wr(11'h710, 32'h00000002);
		wr(11'h700, 32'h00230420);
		@(posedge core_clk_i);
		bank0_req_i[10] <= 1'b1;
		external_request_b_i <= 1'b1;
		beats(3'h4, 4, 36'h010200010, 32'h00006000, 1, 1'b1, 2'h0, 1'b1);
		beats(3'h7, 2, 36'h230000000, 32'h00007000, 4, 1'b0, 2'h2, 1'b0);
		rd(11'h418, v);
		chk(v, 32'h0);
		$display("test buffer_b_and_pin_b done");
		end_sim();
	end
endmodule
